// >>> logic/spm_monitor.sv
// Front-panel monitor: position pages, command scaling, present fault and history.
// Assumes synchronous inputs; fault_active_i has one bit per code 0..99.
`timescale 1ns/1ps
module spm_monitor #(
  parameter int unsigned CYCLE_CLKS = spm_pkg::CYCLE_CLKS,
  parameter int          FACTOR_W   = 16,
  parameter int          VOLT_W     = 16
) (
  // Clock and reset
  input  wire logic                              mclk_i,
  input  wire logic                              rst_n_i,
  // Encoder
  input  wire logic                              enc_absolute_i,
  input  wire logic signed [spm_pkg::POS_W-1:0]  enc_value_i,
  input  wire logic                              fb_pulse_i,
  input  wire logic                              fb_dir_i,
  // Pulse command
  input  wire logic                              cmd_pulse_i,
  input  wire logic                              cmd_dir_i,
  // Analog commands and factors
  input  wire logic signed [VOLT_W-1:0]          speed_cmd_voltage_page_i,
  input  wire logic signed [VOLT_W-1:0]          torque_cmd_voltage_page_i,
  input  wire logic        [FACTOR_W-1:0]        speed_input_factor_i,
  input  wire logic        [FACTOR_W-1:0]        torque_input_factor_i,
  // Faults and hours
  input  wire logic        [99:0]                fault_active_i,
  input  wire logic                              alarm_event_i,
  input  wire logic        [spm_pkg::CODE_W-1:0] alarm_code_i,
  input  wire logic        [spm_pkg::HOURS_W-1:0] op_hours_i,
  // Panel keys
  input  wire logic                              key_set_i,
  input  wire logic                              key_updown_i,
  input  wire logic                              clear_item_sel_i,
  input  wire logic                              hist_item_sel_i,
  input  wire logic        [spm_pkg::HIST_AW-1:0] hist_index_i,
  // Position pages
  output logic             [13:0]                feedback_pos_low_page_o,
  output logic             [13:0]                feedback_pos_high_page_o,
  output logic                                   feedback_pos_neg_o,
  output logic             [13:0]                command_pos_low_page_o,
  output logic             [13:0]                command_pos_high_page_o,
  output logic                                   command_pos_neg_o,
  // Scaled commands
  output logic signed      [FACTOR_W+VOLT_W:0]   speed_o,
  output logic signed      [FACTOR_W+VOLT_W:0]   torque_o,
  // Fault display
  output logic             [spm_pkg::CODE_W-1:0] present_fault_item_o,
  output logic             [spm_pkg::HOURS_W-1:0] hist_value_o,
  output logic                                   hist_shows_hours_o,
  output logic                                   history_clear_item_blink_o
);

  localparam int PW = spm_pkg::POS_W;
  localparam int HW = spm_pkg::CODE_W + spm_pkg::HOURS_W;
  localparam int RW = FACTOR_W + VOLT_W + 1;

  // ----------------------------------------------------------------
  // Position accumulators
  // ----------------------------------------------------------------
  logic signed [PW-1:0] fb_cnt_r,  fb_cnt_nxt;
  logic signed [PW-1:0] cmd_cnt_r, cmd_cnt_nxt;
  logic signed [PW-1:0] fb_disp;
  logic                 seeded_r,  seeded_nxt;

  always_comb begin
    fb_cnt_nxt  = fb_cnt_r;
    cmd_cnt_nxt = cmd_cnt_r;
    seeded_nxt  = 1'b1;
    if (!seeded_r) begin
      fb_cnt_nxt  = '0;
      cmd_cnt_nxt = enc_absolute_i ? enc_value_i : '0;
    end else begin
      if (fb_pulse_i) begin
        fb_cnt_nxt = fb_dir_i ? fb_cnt_r - PW'(1) : fb_cnt_r + PW'(1);
      end
      if (cmd_pulse_i) begin
        cmd_cnt_nxt = cmd_dir_i ? cmd_cnt_r - PW'(1) : cmd_cnt_r + PW'(1);
      end
    end
    // Incremental count is scaled at display time so wrap keeps working
    fb_disp = enc_absolute_i ? enc_value_i : PW'(fb_cnt_r * spm_pkg::INC_MULT);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fb_cnt_r  <= '0;
      cmd_cnt_r <= '0;
      seeded_r  <= 1'b0;
    end else begin
      fb_cnt_r  <= fb_cnt_nxt;
      cmd_cnt_r <= cmd_cnt_nxt;
      seeded_r  <= seeded_nxt;
    end
  end

  spm_page_split u_fb_pages (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .count_i     (fb_disp),
    .low_page_o  (feedback_pos_low_page_o),
    .high_page_o (feedback_pos_high_page_o),
    .neg_o       (feedback_pos_neg_o)
  );

  spm_page_split u_cmd_pages (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .count_i     (cmd_cnt_r),
    .low_page_o  (command_pos_low_page_o),
    .high_page_o (command_pos_high_page_o),
    .neg_o       (command_pos_neg_o)
  );

  // ----------------------------------------------------------------
  // Speed and torque scaling
  // ----------------------------------------------------------------
  logic signed [RW-1:0] speed_nxt;
  logic signed [RW-1:0] torque_nxt;

  always_comb begin
    speed_nxt  = RW'(($signed({1'b0, speed_input_factor_i}) * speed_cmd_voltage_page_i)
                 / spm_pkg::SPEED_DIV);
    torque_nxt = RW'($signed({1'b0, torque_input_factor_i}) * torque_cmd_voltage_page_i);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      speed_o  <= '0;
      torque_o <= '0;
    end else begin
      speed_o  <= speed_nxt;
      torque_o <= torque_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Present fault rotation
  // ----------------------------------------------------------------
  logic [31:0]                tick_r,   tick_nxt;
  logic [6:0]                 cur_r,    cur_nxt;
  logic [spm_pkg::CODE_W-1:0] fault_nxt;
  logic                       found;
  logic [6:0]                 idx;

  always_comb begin
    tick_nxt  = tick_r;
    cur_nxt   = cur_r;
    found     = 1'b0;
    idx       = '0;
    // A shown code that has gone away is replaced at once, not after a full period
    if ((tick_r >= CYCLE_CLKS - 1) || !fault_active_i[cur_r]) begin
      tick_nxt = '0;
      // Next active code after the one shown, wrapping round
      for (int k = 1; k <= 100; k++) begin
        idx = 7'((int'(cur_r) + k) % 100);
        if (!found && fault_active_i[idx]) begin
          found   = 1'b1;
          cur_nxt = idx;
        end
      end
    end else begin
      tick_nxt = tick_r + 32'h1;
    end
    if (fault_active_i == '0) begin
      fault_nxt = spm_pkg::DASH_CODE;
    end else if (fault_active_i[cur_r]) begin
      fault_nxt = spm_pkg::CODE_W'(cur_r);
    end else begin
      fault_nxt = present_fault_item_o;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tick_r               <= '0;
      cur_r                <= '0;
      present_fault_item_o <= spm_pkg::DASH_CODE;
    end else begin
      tick_r               <= tick_nxt;
      cur_r                <= cur_nxt;
      present_fault_item_o <= fault_nxt;
    end
  end

  // ----------------------------------------------------------------
  // History clear sequence and entry display
  // ----------------------------------------------------------------
  spm_pkg::spm_clr_t clr_st_r, clr_st_nxt;
  logic              do_clear;
  logic              push;
  logic              hours_r,  hours_nxt;
  logic [HW-1:0]     rd_data;
  logic [spm_pkg::HOURS_W-1:0] hval_nxt;

  always_comb begin
    clr_st_nxt = clr_st_r;
    do_clear   = 1'b0;
    case (clr_st_r)
      spm_pkg::SPM_CLR_IDLE: begin
        if (clear_item_sel_i && key_set_i) begin
          clr_st_nxt = spm_pkg::SPM_CLR_BLINK;
        end
      end
      spm_pkg::SPM_CLR_BLINK: begin
        if (key_updown_i) begin
          clr_st_nxt = spm_pkg::SPM_CLR_IDLE;
        end else if (key_set_i) begin
          do_clear   = 1'b1;
          clr_st_nxt = spm_pkg::SPM_CLR_IDLE;
        end
      end
      default: clr_st_nxt = spm_pkg::SPM_CLR_IDLE;
    endcase
    // Warnings share the fault inputs but are kept out of the log
    push = alarm_event_i && (alarm_code_i < spm_pkg::WARN_FIRST) && !do_clear;
    hours_nxt = hours_r;
    if (!hist_item_sel_i) begin
      hours_nxt = 1'b0;
    end else if (key_set_i) begin
      hours_nxt = !hours_r;
    end
    hval_nxt = hours_r ? rd_data[spm_pkg::HOURS_W-1:0]
                       : spm_pkg::HOURS_W'(rd_data[HW-1:spm_pkg::HOURS_W]);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      clr_st_r                   <= spm_pkg::SPM_CLR_IDLE;
      hours_r                    <= 1'b0;
      hist_value_o               <= '0;
      hist_shows_hours_o         <= 1'b0;
      history_clear_item_blink_o <= 1'b0;
    end else begin
      clr_st_r                   <= clr_st_nxt;
      hours_r                    <= hours_nxt;
      hist_value_o               <= hval_nxt;
      hist_shows_hours_o         <= hours_r;
      history_clear_item_blink_o <= (clr_st_nxt == spm_pkg::SPM_CLR_BLINK);
    end
  end

  spm_hist_mem u_hist (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .push_i      (push),
    .push_data_i ({alarm_code_i, op_hours_i}),
    .clear_i     (do_clear),
    .rd_addr_i   (hist_index_i),
    .rd_data_o   (rd_data)
  );

endmodule : spm_monitor

// >>> inc/spm_pkg.sv
// Constants and types for the servo position monitor and alarm log.
// Assumes one 20 MHz clock and a synchronous active-low reset.
//
// Behaviour
// - Feedback display shows the absolute value, or incremental pulses times four.
// - Feedback display split into low and high four-digit pages.
// - Feedback display signed to 99999999; ninth digit dropped.
// - Command accumulator starts at encoder value or zero, then adds pulses.
// - Command display split into low and high four-digit pages.
// - Command display signed to 99999999; ninth digit dropped.
// - Speed equals speed input factor times voltage divided by ten.
// - Torque equals torque input factor times torque voltage.
// - History keeps eight newest alarms with operating hours.
// - Warnings are reported but never stored in history.
// - Set key on a history code shows that entry's hours.
// - Present fault item shows the active alarm or warning code.
// - Clear function erases every history entry.
// - Several active faults cycle every 500 ms; none shows a dash pair.
package spm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned CYCLE_MS      = 500;
  localparam int unsigned CYCLE_CLKS    = CLK_HZ / 1000 * CYCLE_MS;

  // ----------------------------------------------------------------
  // Display arithmetic
  // ----------------------------------------------------------------
  localparam int          POS_W         = 32;
  localparam int          POS_MOD       = 100000000;
  localparam int          PAGE_MOD      = 10000;
  localparam int          INC_MULT      = 4;
  localparam int          SPEED_DIV     = 10;
  localparam int          HIST_DEPTH    = 8;
  localparam int          HIST_AW       = 3;
  localparam int          CODE_W        = 8;
  localparam int          HOURS_W       = 17;
  localparam logic [7:0]  WARN_FIRST    = 8'h5A;  // Codes 90 and above are warnings
  localparam logic [7:0]  DASH_CODE     = 8'hFF;  // Dash pair on the panel
  localparam logic [7:0]  EMPTY_CODE    = 8'h00;

  typedef enum logic [1:0] {SPM_CLR_IDLE, SPM_CLR_BLINK} spm_clr_t;

endpackage : spm_pkg

// >>> logic/spm_hist_mem.sv
// Eight-entry alarm history held as a shift register, newest in slot 0.
// Assumes writer never pushes and clears in the same cycle with priority other than clear.
`timescale 1ns/1ps
module spm_hist_mem #(
  parameter int DEPTH = spm_pkg::HIST_DEPTH,
  parameter int DW    = spm_pkg::CODE_W + spm_pkg::HOURS_W
) (
  // Clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  // Write side
  input  wire logic                       push_i,
  input  wire logic [DW-1:0]              push_data_i,
  input  wire logic                       clear_i,
  // Read side
  input  wire logic [spm_pkg::HIST_AW-1:0] rd_addr_i,
  output logic      [DW-1:0]              rd_data_o
);

  logic [DW-1:0] mem_r   [DEPTH];
  logic [DW-1:0] mem_nxt [DEPTH];
  logic [DW-1:0] rd_nxt;

  // ----------------------------------------------------------------
  // Shift on push, wipe on clear
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_slot
      always_comb begin
        mem_nxt[g] = mem_r[g];
        if (clear_i) begin
          mem_nxt[g] = '0;
        end else if (push_i) begin
          if (g == 0) begin
            mem_nxt[g] = push_data_i;
          end else begin
            mem_nxt[g] = mem_r[(g > 0) ? g - 1 : 0];
          end
        end
      end
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          mem_r[g] <= '0;
        end else begin
          mem_r[g] <= mem_nxt[g];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_nxt = mem_r[rd_addr_i];
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= rd_nxt;
    end
  end

endmodule : spm_hist_mem

// >>> logic/spm_page_split.sv
// Wraps a signed count to eight digits and splits the magnitude into two pages.
// Assumes the input changes by a bounded step, so one modulo folds it back.
`timescale 1ns/1ps
module spm_page_split (
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  // Count
  input  wire logic signed [spm_pkg::POS_W-1:0] count_i,
  // Pages
  output logic             [13:0]        low_page_o,
  output logic             [13:0]        high_page_o,
  output logic                           neg_o
);

  logic [spm_pkg::POS_W-1:0] mag;
  logic [26:0]               wrapped;
  logic [13:0]               low_nxt;
  logic [13:0]               high_nxt;

  // ----------------------------------------------------------------
  // Magnitude, eight-digit wrap, page split
  // ----------------------------------------------------------------
  always_comb begin
    mag      = count_i[spm_pkg::POS_W-1] ? 32'(-count_i) : 32'(count_i);
    wrapped  = 27'(mag % 32'(spm_pkg::POS_MOD));
    low_nxt  = 14'(wrapped % 27'(spm_pkg::PAGE_MOD));
    high_nxt = 14'(wrapped / 27'(spm_pkg::PAGE_MOD));
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      low_page_o  <= '0;
      high_page_o <= '0;
      neg_o       <= 1'b0;
    end else begin
      low_page_o  <= low_nxt;
      high_page_o <= high_nxt;
      neg_o       <= count_i[spm_pkg::POS_W-1] && (wrapped != '0);
    end
  end

endmodule : spm_page_split

// >>> sim/spm_enc_model.sv
// Encoder and pulse command source facing the monitor.
// Assumes the bench starts one burst at a time and holds load_i high in reset.
`timescale 1ns/1ps
module spm_enc_model (
  // Control
  input  wire logic               mclk_i,
  input  wire logic               load_i,
  input  wire logic signed [31:0] seed_i,
  input  wire logic               start_i,
  input  wire logic               to_cmd_i,
  input  wire logic               dir_i,
  input  wire logic               slow_i,
  input  wire logic [7:0]         len_i,
  // Pulse lines
  output logic                    fb_pulse_o,
  output logic                    fb_dir_o,
  output logic                    cmd_pulse_o,
  output logic                    cmd_dir_o,
  output logic signed [31:0]      enc_value_o,
  output logic                    busy_o
);
  logic [7:0] left_r;
  logic       gap_r;
  logic       fire;
  assign fire   = (left_r != 8'h00) && !gap_r;
  assign busy_o = (left_r != 8'h00) || fb_pulse_o || cmd_pulse_o;
  always_ff @(posedge mclk_i) begin
    fb_pulse_o  <= fire && !to_cmd_i && !load_i;
    cmd_pulse_o <= fire && to_cmd_i && !load_i;
    // Direction means nothing between pulses, so it wobbles there
    fb_dir_o    <= fire ? dir_i : !fb_dir_o;
    cmd_dir_o   <= fire ? dir_i : !cmd_dir_o;
    if (load_i) begin
      left_r      <= 8'h00;
      gap_r       <= 1'b0;
      fb_dir_o    <= 1'b0;
      cmd_dir_o   <= 1'b0;
      enc_value_o <= seed_i;
    end else if (start_i) begin
      left_r <= len_i;
      gap_r  <= 1'b0;
    end else if (left_r != 8'h00) begin
      gap_r <= slow_i && !gap_r;
      if (fire) begin
        left_r <= left_r - 8'h01;
        if (!to_cmd_i) begin
          enc_value_o <= dir_i ? enc_value_o - 32'sh1 : enc_value_o + 32'sh1;
        end
      end
    end
  end
endmodule : spm_enc_model

// >>> sim/spm_chk_monitor.sv
// Assertions on the monitor's ports.
// Assumes keys are one-cycle pulses and a short fault cycle in sim.
`timescale 1ns/1ps
module spm_chk #(
  parameter int FACTOR_W = 16,
  parameter int VOLT_W   = 16
) (
  input wire logic                             mclk_i,
  input wire logic                             rst_n_i,
  input wire logic                             cmd_pulse_i,
  input wire logic signed [VOLT_W-1:0]         speed_cmd_voltage_page_i,
  input wire logic signed [VOLT_W-1:0]         torque_cmd_voltage_page_i,
  input wire logic [FACTOR_W-1:0]              speed_input_factor_i,
  input wire logic [FACTOR_W-1:0]              torque_input_factor_i,
  input wire logic [99:0]                      fault_active_i,
  input wire logic                             key_set_i,
  input wire logic                             key_updown_i,
  input wire logic                             clear_item_sel_i,
  input wire logic [13:0]                      feedback_pos_low_page_o,
  input wire logic [13:0]                      feedback_pos_high_page_o,
  input wire logic [13:0]                      command_pos_low_page_o,
  input wire logic [13:0]                      command_pos_high_page_o,
  input wire logic                             command_pos_neg_o,
  input wire logic signed [FACTOR_W+VOLT_W:0]  speed_o,
  input wire logic signed [FACTOR_W+VOLT_W:0]  torque_o,
  input wire logic [spm_pkg::CODE_W-1:0]       present_fault_item_o,
  input wire logic                             history_clear_item_blink_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [99:0] f1_r, f1_nxt, f2_r, f2_nxt;
  always_comb begin
    f1_nxt = rst_n_i ? fault_active_i : '0;
    f2_nxt = rst_n_i ? f1_r : '0;
  end
  always_ff @(posedge mclk_i) begin
    f1_r <= f1_nxt;
    f2_r <= f2_nxt;
  end
  a_speed_scale: assert property ($past(rst_n_i) |-> speed_o ==
    ($signed({1'b0, $past(speed_input_factor_i)}) * $past(speed_cmd_voltage_page_i)) / 33'sh0A)
    else $error("speed output off");
  a_torque_scale: assert property ($past(rst_n_i) |-> torque_o ==
    $signed({1'b0, $past(torque_input_factor_i)}) * $past(torque_cmd_voltage_page_i))
    else $error("torque output off");
  a_dash_none: assert property (!(|f1_r) && !(|f2_r) |-> present_fault_item_o == 8'hFF)
    else $error("dash pair missing");
  a_code_range: assert property (present_fault_item_o == 8'hFF ||
    present_fault_item_o < 8'h64) else $error("fault code out of range");
  a_fb_range: assert property (feedback_pos_low_page_o <= 14'h270F &&
    feedback_pos_high_page_o <= 14'h270F) else $error("feedback page over four digits");
  a_cmd_range: assert property (command_pos_low_page_o <= 14'h270F &&
    command_pos_high_page_o <= 14'h270F) else $error("command page over four digits");
  a_neg_nonzero: assert property (command_pos_neg_o |->
    (command_pos_low_page_o | command_pos_high_page_o) != 14'h0) else $error("minus zero");
  a_clear_arm: assert property (key_set_i && clear_item_sel_i &&
    !history_clear_item_blink_o |=> history_clear_item_blink_o) else $error("no blink");
  a_clear_leave: assert property (history_clear_item_blink_o &&
    (key_updown_i || key_set_i && clear_item_sel_i) |=> !history_clear_item_blink_o)
    else $error("blink stuck");
  a_cmd_hold: assert property ((!cmd_pulse_i)[*5] |-> $stable(command_pos_low_page_o) &&
    $stable(command_pos_high_page_o)) else $error("command moved without pulses");
  c_clear_done: cover property (history_clear_item_blink_o && key_set_i && clear_item_sel_i);
  c_cancel: cover property (history_clear_item_blink_o && key_updown_i);
  c_fault_step: cover property (present_fault_item_o != 8'hFF ##1 $changed(present_fault_item_o));
endmodule : spm_chk
bind spm_monitor spm_chk #(.FACTOR_W(FACTOR_W), .VOLT_W(VOLT_W)) u_spm_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_pulse_i(cmd_pulse_i),
  .speed_cmd_voltage_page_i(speed_cmd_voltage_page_i),
  .torque_cmd_voltage_page_i(torque_cmd_voltage_page_i),
  .speed_input_factor_i(speed_input_factor_i), .torque_input_factor_i(torque_input_factor_i),
  .fault_active_i(fault_active_i), .key_set_i(key_set_i), .key_updown_i(key_updown_i),
  .clear_item_sel_i(clear_item_sel_i), .feedback_pos_low_page_o(feedback_pos_low_page_o),
  .feedback_pos_high_page_o(feedback_pos_high_page_o),
  .command_pos_low_page_o(command_pos_low_page_o),
  .command_pos_high_page_o(command_pos_high_page_o), .command_pos_neg_o(command_pos_neg_o),
  .speed_o(speed_o), .torque_o(torque_o), .present_fault_item_o(present_fault_item_o),
  .history_clear_item_blink_o(history_clear_item_blink_o));

// >>> sim/tb_servo_pulse_monitor_alarm_log.sv
// Self-checking bench for the position monitor and alarm log.
// Assumes the checker binds itself; the fault cycle is cut to 20 clocks.
`timescale 1ns/1ps
module tb_servo_pulse_monitor_alarm_log;
  typedef struct {
    logic [15:0] f; logic signed [15:0] v; logic signed [32:0] s; logic signed [32:0] t;
  } spm_row_t;
  spm_row_t rows[5] = '{
    '{16'h0064, 16'sh0032, 33'sh1F4, 33'sh1388},
    '{16'h0064, -16'sh37, -33'sh226, -33'sh157C},
    '{16'h0007, 16'sh0003, 33'sh2, 33'sh15},
    '{16'h0003, -16'sh7, -33'sh2, -33'sh15},
    '{16'hFFFF, 16'sh8000, -33'shCCCC000, -33'sh7FFF8000}};
  logic clk = 1'b0, rst_n = 1'b0, abs_m = 1'b0, ev = 1'b0, kset = 1'b0, kud = 1'b0;
  logic csel = 1'b0, hsel = 1'b0, st = 1'b0, tocmd = 1'b0, dir = 1'b0, slow = 1'b0;
  logic ld = 1'b1, fbp, fbd, cp, cd, busy, fn, cn, hh, blk;
  logic [15:0] sf = '0, tf = '0;
  logic signed [15:0] sv = '0, tv = '0;
  logic [99:0] flt = '0, got;
  logic [7:0] acode = '0, len = '0, pfi;
  logic [16:0] hrs = '0, hv;
  logic [2:0] idx = '0;
  logic signed [31:0] seed = '0, encv;
  logic signed [32:0] spd, trq;
  logic [13:0] fl, fh, cl, ch;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  spm_enc_model u_spm_enc_model (.mclk_i(clk), .load_i(ld), .seed_i(seed), .start_i(st),
    .to_cmd_i(tocmd), .dir_i(dir), .slow_i(slow), .len_i(len), .fb_pulse_o(fbp),
    .fb_dir_o(fbd), .cmd_pulse_o(cp), .cmd_dir_o(cd), .enc_value_o(encv), .busy_o(busy));
  spm_monitor #(.CYCLE_CLKS(20)) u_spm_monitor (.mclk_i(clk), .rst_n_i(rst_n),
    .enc_absolute_i(abs_m), .enc_value_i(encv), .fb_pulse_i(fbp), .fb_dir_i(fbd),
    .cmd_pulse_i(cp), .cmd_dir_i(cd), .speed_cmd_voltage_page_i(sv),
    .torque_cmd_voltage_page_i(tv), .speed_input_factor_i(sf), .torque_input_factor_i(tf),
    .fault_active_i(flt), .alarm_event_i(ev), .alarm_code_i(acode), .op_hours_i(hrs),
    .key_set_i(kset), .key_updown_i(kud), .clear_item_sel_i(csel), .hist_item_sel_i(hsel),
    .hist_index_i(idx), .feedback_pos_low_page_o(fl), .feedback_pos_high_page_o(fh),
    .feedback_pos_neg_o(fn), .command_pos_low_page_o(cl), .command_pos_high_page_o(ch),
    .command_pos_neg_o(cn), .speed_o(spd), .torque_o(trq), .present_fault_item_o(pfi),
    .hist_value_o(hv), .hist_shows_hours_o(hh), .history_clear_item_blink_o(blk));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (e !== g) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic chk_pos(input string n, input logic signed [31:0] c,
                         input logic [13:0] gh, input logic [13:0] gl, input logic gs);
    logic signed [31:0] m;
    m = (c < 0) ? -c : c;
    m = m % 32'sh5F5E100;
    chk({n, " high"}, 33'(m / 32'sh2710), 33'(gh));
    chk({n, " low"}, 33'(m % 32'sh2710), 33'(gl));
    chk({n, " sign"}, 33'((c < 0) && (m != 0)), 33'(gs));
  endtask : chk_pos
  task automatic do_reset(input logic a, input logic signed [31:0] s);
    abs_m <= a;
    seed  <= s;
    ld    <= 1'b1;
    rst_n <= 1'b0;
    tick(2);
    ld    <= 1'b0;
    rst_n <= 1'b1;
    tick(4);
  endtask : do_reset
  task automatic burst(input logic c, input logic d, input logic s, input logic [7:0] n);
    tocmd <= c;
    dir   <= d;
    slow  <= s;
    len   <= n;
    st    <= 1'b1;
    tick(1);
    st <= 1'b0;
    tick(2);
    for (int i = 0; busy && i < 600; i++) tick(1);
    tick(4);
  endtask : burst
  task automatic push(input logic [7:0] c);
    acode <= c;
    hrs   <= {9'h0, c} * 17'h64;
    ev    <= 1'b1;
    tick(1);
    ev <= 1'b0;
    tick(1);
  endtask : push
  task automatic key(input logic s);
    if (s) kset <= 1'b1;
    else kud <= 1'b1;
    tick(1);
    kset <= 1'b0;
    kud  <= 1'b0;
    tick(3);
  endtask : key
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    do_reset(1'b0, 32'sh0);
    foreach (rows[i]) begin
      sf <= rows[i].f;
      tf <= rows[i].f;
      sv <= rows[i].v;
      tv <= rows[i].v;
      tick(2);
      chk("speed", rows[i].s, spd);
      chk("torque", rows[i].t, trq);
    end
    burst(1'b0, 1'b0, 1'b0, 8'h05);
    chk_pos("feedback", 32'sh14, fh, fl, fn);
    burst(1'b0, 1'b1, 1'b1, 8'h0A);
    chk_pos("feedback", -32'sh14, fh, fl, fn);
    burst(1'b1, 1'b1, 1'b0, 8'h03);
    chk_pos("command", -32'sh3, ch, cl, cn);
    do_reset(1'b1, 32'sh5F5E0FE);
    chk_pos("feedback", 32'sh5F5E0FE, fh, fl, fn);
    chk_pos("command", 32'sh5F5E0FE, ch, cl, cn);
    burst(1'b1, 1'b0, 1'b0, 8'h03);
    chk_pos("command wrap", 32'sh5F5E101, ch, cl, cn);
    burst(1'b0, 1'b0, 1'b1, 8'h03);
    chk_pos("feedback wrap", 32'sh5F5E101, fh, fl, fn);
    chk("dash idle", 33'hFF, 33'(pfi));
    flt <= (100'h1 << 10) | (100'h1 << 20) | (100'h1 << 91);
    got = '0;
    repeat (90) begin
      tick(1);
      if (pfi != 8'hFF) got[pfi] = 1'b1;
    end
    chk("fault codes", 33'h1, 33'(got === flt));
    flt <= '0;
    tick(3);
    chk("dash again", 33'hFF, 33'(pfi));
    for (int i = 1; i < 10; i++) push(8'(i));
    push(8'h5F);
    hsel <= 1'b1;
    tick(3);
    chk("newest code", 33'h9, 33'(hv));
    idx <= 3'h7;
    tick(3);
    chk("oldest code", 33'h2, 33'(hv));
    key(1'b1);
    chk("oldest hours", 33'h0C8, 33'(hv));
    chk("hours shown", 33'h1, 33'(hh));
    key(1'b1);
    hsel <= 1'b0;
    csel <= 1'b1;
    key(1'b1);
    chk("clear blink", 33'h1, 33'(blk));
    key(1'b0);
    chk("clear cancel", 33'h0, 33'(blk));
    key(1'b1);
    key(1'b1);
    chk("clear done", 33'h0, 33'(blk));
    csel <= 1'b0;
    hsel <= 1'b1;
    idx  <= 3'h0;
    tick(3);
    chk("cleared slot", 33'h0, 33'(hv));
    csel <= 1'b1;
    key(1'b1);
    rst_n <= 1'b0;
    tick(2);
    chk("reset blink", 33'h0, 33'(blk));
    chk("reset fault", 33'hFF, 33'(pfi));
    finish_test();
  end
endmodule : tb_servo_pulse_monitor_alarm_log
